// ---- pkg/sdx_pkg.sv ----
`default_nettype none
package sdx_pkg;
    // telegram geometry
    localparam int          TEL_BYTES     = 8;
    localparam int          TEL_BITS      = 64;
    localparam int          ID_BITS       = 11;
    localparam int          NODE_BITS     = 7;
    localparam logic [10:0] REQ_BASE_ID   = 11'h600;
    localparam logic [10:0] RSP_BASE_ID   = 11'h580;
    // specifier codes
    localparam logic [7:0]  SPEC_UPL_REQ  = 8'h40;
    localparam logic [7:0]  SPEC_UPL_1    = 8'h4F;
    localparam logic [7:0]  SPEC_UPL_2    = 8'h4B;
    localparam logic [7:0]  SPEC_UPL_3    = 8'h47;
    localparam logic [7:0]  SPEC_UPL_4    = 8'h43;
    localparam logic [7:0]  SPEC_DNL_REQ  = 8'h22;
    localparam logic [7:0]  SPEC_DNL_1    = 8'h2F;
    localparam logic [7:0]  SPEC_DNL_2    = 8'h2B;
    localparam logic [7:0]  SPEC_DNL_3    = 8'h27;
    localparam logic [7:0]  SPEC_DNL_4    = 8'h23;
    localparam logic [7:0]  SPEC_DNL_ACK  = 8'h60;
    localparam logic [7:0]  SPEC_ABORT    = 8'h80;
    // abort codes
    localparam logic [31:0] ERR_BAD_CMD   = 32'h05040001;
    localparam logic [31:0] ERR_NO_OBJ    = 32'h06020000;
    // long string objects not served here
    localparam logic [15:0] IDX_DEV_NAME  = 16'h1008;
    localparam logic [15:0] IDX_HW_VER    = 16'h1009;
    localparam logic [15:0] IDX_SW_VER    = 16'h100A;
    // byte positions in the 64-bit telegram, byte 0 in bits 7:0
    localparam int          POS_SPEC      = 0;
    localparam int          POS_IDX_LO    = 8;
    localparam int          POS_IDX_HI    = 16;
    localparam int          POS_SUB       = 24;
    localparam int          POS_VAL       = 32;
    // bus-load averaging window
    localparam int          CLK_HZ        = 100_000_000;
    localparam int          LOAD_WIN_MS   = 100;
    localparam int          LOAD_WIN_CYC  = CLK_HZ / 1000 * LOAD_WIN_MS;
endpackage
`default_nettype wire

// ---- pkg/sdx_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// one telegram each way: request client to server, reply server to client
interface sdx_link_if;
    logic        req_valid;
    logic        req_ready;
    logic [10:0] req_id;
    logic [63:0] req_data;
    logic        rsp_valid;
    logic        rsp_ready;
    logic [10:0] rsp_id;
    logic [63:0] rsp_data;
    modport server (
        input  req_valid, req_id, req_data, rsp_ready,
        output req_ready, rsp_valid, rsp_id, rsp_data
    );
    modport client (
        output req_valid, req_id, req_data, rsp_ready,
        input  req_ready, rsp_valid, rsp_id, rsp_data
    );
endinterface
`default_nettype wire

// ---- design/sdx_load_avg.sv ----
`timescale 1ns/1ps
`default_nettype none
// busy-cycle share over a fixed window, in percent
module sdx_load_avg #(
    parameter int WIN_CYC = sdx_pkg::LOAD_WIN_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       busy_in,
    output logic      [6:0] load_pct_out
);
    localparam int CW = $clog2(WIN_CYC + 1);
    logic [CW-1:0] win_q;
    logic [CW-1:0] busy_q;
    logic [CW+6:0] prod;
    wire           win_end = (win_q == CW'(WIN_CYC - 1));

    assign prod = (CW+7)'(busy_q) * (CW+7)'(100);

    // window and busy counters, figure updated once per window
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            win_q        <= '0;
            busy_q       <= '0;
            load_pct_out <= 7'h00;
        end else if (win_end) begin
            win_q        <= '0;
            busy_q       <= '0;
            load_pct_out <= 7'(prod / (CW+7)'(WIN_CYC));
        end else begin
            win_q  <= win_q + CW'(1);
            busy_q <= busy_q + CW'(busy_in);
        end
    end
endmodule
`default_nettype wire

// ---- design/sdx_server.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - entry selected by 16-bit index, 8-bit sub-index
// - server acts only on client requests
// - one request then exactly one reply
// - one request id, one reply id
// - telegrams are 8 bytes, byte 0 specifier
// - long string objects refused
// - upload request 0x600+node, 0x40, zeros
// - upload reply 0x580+node, echo, value
// - index and value little-endian
// - short values sit in lowest bytes
// - upload specifier encodes valid byte count
// - download request 0x600+node, 0x22, value
// - download confirmed, upload echoes index
// - bus load averaged over long window
// - download confirm 0x60, echo, zeros
// - abort 0x80, echo, little-endian error code
// - abort bad specifier or missing object
// - accept size-coded download, use low bytes
module sdx_server #(
    parameter int LOAD_WIN = sdx_pkg::LOAD_WIN_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic [6:0] node_id_in,
    sdx_link_if.server      link,
    // object dictionary access, answered combinationally
    output logic            od_rd_out,
    output logic            od_wr_out,
    output logic     [15:0] od_index_out,
    output logic      [7:0] od_sub_out,
    output logic     [31:0] od_wdata_out,
    input  wire logic       od_exists_in,
    input  wire logic [2:0] od_len_in,
    input  wire logic[31:0] od_rdata_in,
    output logic      [6:0] bus_load_out
);
    typedef enum logic [1:0] {SDX_IDLE, SDX_EXEC, SDX_REPLY} sdx_state_t;
    sdx_state_t  state_q;
    logic [63:0] req_q;
    logic [63:0] rsp_q;

    ////////////////////////////////////////////////////////////////////
    // request field decode
    wire [7:0]  spec    = req_q[sdx_pkg::POS_SPEC +: 8];
    wire [15:0] index   = {req_q[sdx_pkg::POS_IDX_HI +: 8],
                           req_q[sdx_pkg::POS_IDX_LO +: 8]};
    wire [7:0]  sub     = req_q[sdx_pkg::POS_SUB +: 8];
    wire [31:0] value   = req_q[sdx_pkg::POS_VAL +: 32];
    wire [23:0] echo    = req_q[31:8];
    wire        my_id   = link.req_id ==
        (sdx_pkg::REQ_BASE_ID + {4'h0, node_id_in});
    wire        is_upl  = spec == sdx_pkg::SPEC_UPL_REQ;
    wire        is_dnl  = spec == sdx_pkg::SPEC_DNL_REQ ||
                          spec == sdx_pkg::SPEC_DNL_1 ||
                          spec == sdx_pkg::SPEC_DNL_2 ||
                          spec == sdx_pkg::SPEC_DNL_3 ||
                          spec == sdx_pkg::SPEC_DNL_4;
    wire        is_long = index == sdx_pkg::IDX_DEV_NAME ||
                          index == sdx_pkg::IDX_HW_VER ||
                          index == sdx_pkg::IDX_SW_VER;
    wire        found   = od_exists_in && !is_long && od_len_in != 3'h0 &&
                          od_len_in <= 3'h4;

    ////////////////////////////////////////////////////////////////////
    // dictionary strobes during the single execute cycle
    assign od_index_out = index;
    assign od_sub_out   = sub;
    assign od_rd_out    = state_q == SDX_EXEC && is_upl;
    assign od_wr_out    = state_q == SDX_EXEC && is_dnl && found;
    // only low bytes up to the entry length are kept
    wire [31:0] len_mask = od_len_in == 3'h1 ? 32'h000000FF :
                           od_len_in == 3'h2 ? 32'h0000FFFF :
                           od_len_in == 3'h3 ? 32'h00FFFFFF : 32'hFFFFFFFF;
    assign od_wdata_out = value & len_mask;

    // upload specifier from entry length
    wire [7:0] upl_spec = od_len_in == 3'h1 ? sdx_pkg::SPEC_UPL_1 :
                          od_len_in == 3'h2 ? sdx_pkg::SPEC_UPL_2 :
                          od_len_in == 3'h3 ? sdx_pkg::SPEC_UPL_3 :
                                              sdx_pkg::SPEC_UPL_4;

    // reply telegram assembly
    wire [63:0] rsp_d =
        !(is_upl || is_dnl) ?
            {sdx_pkg::ERR_BAD_CMD, echo, sdx_pkg::SPEC_ABORT} :
        !found ?
            {sdx_pkg::ERR_NO_OBJ, echo, sdx_pkg::SPEC_ABORT} :
        is_upl ?
            {od_rdata_in & len_mask, echo, upl_spec} :
            {32'h00000000, echo, sdx_pkg::SPEC_DNL_ACK};

    ////////////////////////////////////////////////////////////////////
    // link outputs
    assign link.req_ready = state_q == SDX_IDLE;
    assign link.rsp_valid = state_q == SDX_REPLY;
    assign link.rsp_data  = rsp_q;
    assign link.rsp_id    = sdx_pkg::RSP_BASE_ID + {4'h0, node_id_in};

    // take request, execute, hold reply until taken
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= SDX_IDLE;
            req_q   <= 64'h0;
            rsp_q   <= 64'h0;
        end else begin
            unique case (state_q)
                SDX_IDLE: begin
                    if (link.req_valid && my_id) begin
                        req_q   <= link.req_data;
                        state_q <= SDX_EXEC;
                    end
                end
                SDX_EXEC: begin
                    rsp_q   <= rsp_d;
                    state_q <= SDX_REPLY;
                end
                SDX_REPLY: begin
                    if (link.rsp_ready) begin
                        state_q <= SDX_IDLE;
                    end
                end
                default: state_q <= SDX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus load: link busy while a telegram is offered either way
    sdx_load_avg #(
        .WIN_CYC (LOAD_WIN)
    ) u_load (
        .clk_in       (clk_in),
        .nrst_in      (nrst_in),
        .busy_in      (link.req_valid || link.rsp_valid),
        .load_pct_out (bus_load_out)
    );
endmodule
`default_nettype wire

// ---- design/sdx_client.sv ----
`timescale 1ns/1ps
`default_nettype none
// client end: builds one request, waits for the matching reply
module sdx_client (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        start_in,
    input  wire logic        write_in,
    input  wire logic  [6:0] node_id_in,
    input  wire logic [15:0] index_in,
    input  wire logic  [7:0] sub_in,
    input  wire logic [31:0] wdata_in,
    output logic             busy_out,
    output logic             done_out,
    output logic             abort_out,
    output logic      [31:0] rdata_out,
    output logic       [2:0] rlen_out,
    sdx_link_if.client       link
);
    typedef enum logic [1:0] {CL_IDLE, CL_SEND, CL_WAIT} cl_state_t;
    cl_state_t   state_q;
    logic [63:0] req_q;
    logic  [6:0] node_q;

    ////////////////////////////////////////////////////////////////////
    // request assembly, index low first
    wire [63:0] req_d = write_in ?
        {wdata_in, sub_in, index_in[15:8], index_in[7:0],
         sdx_pkg::SPEC_DNL_REQ} :
        {32'h00000000, sub_in, index_in[15:8], index_in[7:0],
         sdx_pkg::SPEC_UPL_REQ};
    wire        rsp_mine = link.rsp_id ==
        (sdx_pkg::RSP_BASE_ID + {4'h0, node_q});
    wire [7:0]  rspec    = link.rsp_data[7:0];
    wire [2:0]  rlen     = rspec == sdx_pkg::SPEC_UPL_1 ? 3'h1 :
                           rspec == sdx_pkg::SPEC_UPL_2 ? 3'h2 :
                           rspec == sdx_pkg::SPEC_UPL_3 ? 3'h3 :
                           rspec == sdx_pkg::SPEC_UPL_4 ? 3'h4 : 3'h0;

    assign link.req_valid = state_q == CL_SEND;
    assign link.req_data  = req_q;
    assign link.req_id    = sdx_pkg::REQ_BASE_ID + {4'h0, node_q};
    assign link.rsp_ready = state_q == CL_WAIT;
    assign busy_out       = state_q != CL_IDLE;

    // one request, one reply per transfer
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q   <= CL_IDLE;
            req_q     <= 64'h0;
            node_q    <= 7'h00;
            done_out  <= 1'b0;
            abort_out <= 1'b0;
            rdata_out <= 32'h0;
            rlen_out  <= 3'h0;
        end else begin
            done_out <= 1'b0;
            unique case (state_q)
                CL_IDLE: begin
                    if (start_in) begin
                        req_q   <= req_d;
                        node_q  <= node_id_in;
                        state_q <= CL_SEND;
                    end
                end
                CL_SEND: begin
                    if (link.req_ready) begin
                        state_q <= CL_WAIT;
                    end
                end
                CL_WAIT: begin
                    if (link.rsp_valid && rsp_mine) begin
                        done_out  <= 1'b1;
                        abort_out <= rspec == sdx_pkg::SPEC_ABORT;
                        rdata_out <= link.rsp_data[63:32];
                        rlen_out  <= rlen;
                        state_q   <= CL_IDLE;
                    end
                end
                default: state_q <= CL_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- dv/sdx_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// protocol checks on the link between the two ends
module sdx_link_sva #(
    parameter logic [6:0] NODE = 7'h05
) (
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [10:0] req_id,
    input wire logic [63:0] req_data,
    input wire logic        rsp_valid,
    input wire logic        rsp_ready,
    input wire logic [10:0] rsp_id,
    input wire logic [63:0] rsp_data
);
    localparam logic [10:0] REQ_ID = sdx_pkg::REQ_BASE_ID + 11'(NODE);
    localparam logic [10:0] RSP_ID = sdx_pkg::RSP_BASE_ID + 11'(NODE);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // request accepted by the server
    logic take_w;
    assign take_w = req_valid && req_ready && req_id == REQ_ID;
    ////////////////////////////////////////////////////////////////////
    reply_timing_a: assert property (
        take_w |=> !req_ready ##1 rsp_valid)
        else $error("reply not two cycles after take");
    one_reply_a: assert property (
        rsp_valid && rsp_ready |=> !rsp_valid && req_ready)
        else $error("reply repeated or server not idle");
    reply_id_a: assert property (
        rsp_valid |-> rsp_id == RSP_ID)
        else $error("reply on wrong identifier");
    request_id_a: assert property (
        req_valid |-> req_id == REQ_ID)
        else $error("request on wrong identifier");
    index_echo_a: assert property (
        take_w |-> ##2 rsp_data[31:8] == $past(req_data[31:8], 2))
        else $error("index not echoed");
    spec_code_a: assert property (
        rsp_valid |-> rsp_data[7:0] inside
            {8'h4F, 8'h4B, 8'h47, 8'h43, 8'h60, 8'h80})
        else $error("illegal reply specifier");
    confirm_zero_a: assert property (
        rsp_valid && rsp_data[7:0] == 8'h60 |->
            rsp_data[63:32] == 32'h00000000)
        else $error("confirm value bytes not zero");
    byte_len_a: assert property (
        rsp_valid && rsp_data[7:0] == 8'h4F |->
            rsp_data[63:40] == 24'h000000)
        else $error("one-byte value spills over");
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) \
    begin num_errors++; $display("[ERR] %s exp %0h got %0h", nm, exp, got); \
    end end
module tb_top;
    localparam logic [6:0]  NODE = 7'h05;
    localparam logic [10:0] REQ  = sdx_pkg::REQ_BASE_ID + 11'(NODE);
    localparam logic [31:0] VAL  = 32'hA4B3C2D1;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        start = 1'b0;
    logic        write = 1'b0;
    logic [6:0]  node = NODE;
    logic [6:0]  nid_b = NODE + 7'h01;
    logic [15:0] idx = 16'h0000;
    logic [7:0]  sub = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic        busy, done, abort, od_rd, od_wr, od_ex;
    logic [31:0] rdata, od_wd, od_rv;
    logic [31:0] wr_seen = 32'h00000000;
    logic [2:0]  rlen, od_len;
    logic [15:0] od_idx;
    logic [7:0]  od_sub;
    logic [6:0]  load;
    logic [63:0] last_req = 64'h0, last_rsp = 64'h0;
    int          num_errors = 0;
    int          samples_checked = 0;
    sdx_link_if  link ();
    sdx_link_if  link_b ();
    always #5 clk_in = ~clk_in;
    // small dictionary: 0x20xx sized by low index bits, 0x1008 long
    assign od_ex = od_idx[15:8] == 8'h20 || od_idx == sdx_pkg::IDX_DEV_NAME;
    assign od_len = {1'b0, od_idx[1:0]} + 3'h1;
    assign od_rv = VAL;
    // record writes and each telegram seen on the wire
    always @(posedge clk_in) begin
        if (od_wr) wr_seen <= od_wd;
        if (link.req_valid && link.req_ready) last_req <= link.req_data;
        if (link.rsp_valid && link.rsp_ready) last_rsp <= link.rsp_data;
    end
    sdx_server #(.LOAD_WIN(100)) sdx_server_inst (.clk_in(clk_in),
        .nrst_in(nrst_in), .node_id_in(node), .link(link), .od_rd_out(od_rd),
        .od_wr_out(od_wr), .od_index_out(od_idx), .od_sub_out(od_sub),
        .od_wdata_out(od_wd), .od_exists_in(od_ex), .od_len_in(od_len),
        .od_rdata_in(od_rv), .bus_load_out(load));
    sdx_server #(.LOAD_WIN(100)) sdx_server_inst_b (.clk_in(clk_in),
        .nrst_in(nrst_in), .node_id_in(nid_b), .link(link_b), .od_rd_out(),
        .od_wr_out(), .od_index_out(), .od_sub_out(), .od_wdata_out(),
        .od_exists_in(1'b1), .od_len_in(3'h4), .od_rdata_in(32'h0),
        .bus_load_out());
    sdx_client sdx_client_inst (.clk_in(clk_in), .nrst_in(nrst_in),
        .start_in(start), .write_in(write), .node_id_in(node),
        .index_in(idx), .sub_in(sub), .wdata_in(wdata), .busy_out(busy),
        .done_out(done), .abort_out(abort), .rdata_out(rdata),
        .rlen_out(rlen), .link(link));
    sdx_link_sva #(.NODE(NODE)) sdx_link_sva_inst (.clk_in(clk_in),
        .nrst_in(nrst_in), .req_valid(link.req_valid),
        .req_ready(link.req_ready), .req_id(link.req_id),
        .req_data(link.req_data), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_id(link.rsp_id),
        .rsp_data(link.rsp_data));
    ////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one client transfer, waits for done under a bound
    task automatic xfer(input logic wr, input logic [15:0] ix,
                        input logic [31:0] wd);
        int n;
        @(posedge clk_in);
        #1;
        write = wr;
        idx = ix;
        sub = ix[7:0] + 8'h11;
        wdata = wd;
        start = 1'b1;
        @(posedge clk_in);
        #1;
        start = 1'b0;
        n = 0;
        while (done !== 1'b1) begin
            @(posedge clk_in);
            #1;
            n++;
            if (n > 20) begin
                num_errors++;
                wrap_up();
            end
        end
    endtask
    // raw request on the second link, reply sampled mid-cycle
    task automatic b_req(input logic [63:0] d, output logic got,
                         output logic [63:0] rsp);
        @(posedge clk_in);
        #1;
        link_b.req_id = REQ;
        link_b.req_data = d;
        link_b.req_valid = 1'b1;
        @(posedge clk_in);
        #1;
        link_b.req_valid = 1'b0;
        link_b.req_data = ~d;
        got = 1'b0;
        repeat (6) begin
            @(negedge clk_in);
            if (link_b.rsp_valid === 1'b1) begin
                got = 1'b1;
                rsp = link_b.rsp_data;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // uploads of every length
    task automatic s_upload();
        logic [7:0] sp [4] = '{8'h4F, 8'h4B, 8'h47, 8'h43};
        logic [31:0] m;
        for (int k = 1; k <= 4; k++) begin
            m = 32'hFFFFFFFF >> (32 - 8 * k);
            xfer(1'b0, 16'h2000 + 16'(k - 1), 32'h0);
            `CHK("rdata", VAL & m, rdata)
            `CHK("rlen", 3'(k), rlen)
            `CHK("upl spec", sp[k - 1], last_rsp[7:0])
            `CHK("upl reply", {VAL & m, sub, idx}, last_rsp[63:8])
            `CHK("upl req", {32'h0, sub, idx, 8'h40}, last_req)
        end
    endtask
    // download into a two-byte entry, high bytes dropped
    task automatic s_download();
        xfer(1'b1, 16'h2001, 32'h11223344);
        `CHK("written", 32'h00003344, wr_seen)
        `CHK("dnl req", {wdata, sub, idx, 8'h22}, last_req)
        `CHK("confirm", {32'h0, sub, idx, 8'h60}, last_rsp)
        `CHK("dnl rlen", 3'h0, rlen)
    endtask
    // long string object and missing object are refused
    task automatic s_refuse();
        logic [15:0] bad [2] = '{sdx_pkg::IDX_DEV_NAME, 16'h3000};
        for (int k = 0; k < 2; k++) begin
            xfer(1'b0, bad[k], 32'h0);
            `CHK("abort", 1'b1, abort)
            `CHK("abort tel", {sdx_pkg::ERR_NO_OBJ, sub, idx, 8'h80}, last_rsp)
        end
    endtask
    // foreign node, bad specifier, size-coded downloads
    task automatic s_side();
        logic [7:0]  ds [4] = '{8'h2F, 8'h2B, 8'h27, 8'h23};
        logic        got;
        logic [63:0] r;
        b_req({32'h0, 8'h00, 16'h2003, 8'h40}, got, r);
        `CHK("foreign reply", 1'b0, got)
        nid_b = NODE;
        b_req({32'h0, 8'h00, 16'h2003, 8'h99}, got, r);
        `CHK("bad spec", {sdx_pkg::ERR_BAD_CMD, 24'h002003, 8'h80}, r)
        for (int k = 0; k < 4; k++) begin
            b_req({32'h55667788, 8'h00, 16'h2003, ds[k]}, got, r);
            `CHK("sized dnl", {32'h0, 24'h002003, 8'h60}, r)
        end
    endtask
    initial begin
        link_b.req_valid = 1'b0;
        link_b.req_id = 11'h000;
        link_b.req_data = 64'h0;
        link_b.rsp_ready = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        s_upload();
        s_download();
        s_refuse();
        // first window: seven transfers, two busy cycles each, of 100
        for (int w = 0; w < 150 && load === 7'h00; w++) begin
            @(posedge clk_in);
            #1;
        end
        `CHK("bus load busy", 7'h0E, load)
        s_side();
        // two idle windows leave no load
        repeat (250) @(posedge clk_in);
        `CHK("bus load", 7'h00, load)
        wrap_up();
    end
endmodule
`default_nettype wire
